// ===== pkg/power_pkg.sv
// Constants shared by the power-down and sleep control block
package power_pkg;

    // ------------------------------------------------------------------
    // Register addresses on the three-wire configuration port
    // ------------------------------------------------------------------
    localparam logic [4:0] ADDR_POWER_MODE = 5'h00;
    localparam logic [4:0] ADDR_SLEEP_CTRL = 5'h01;
    localparam logic [4:0] ADDR_STATUS = 5'h02;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] POWER_MODE_RESET = 8'h00;
    localparam logic [7:0] SLEEP_CTRL_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    // Power mode control
    localparam int PWR_FULL_PD_BIT = 4;
    localparam int PWR_AUTO_PD_BIT = 3;
    // Sleep control: per-channel sleeps and block power-downs
    localparam int SLP_MAIN_SLEEP_LSB = 0;
    localparam int SLP_AUX_SLEEP_LSB = 2;
    localparam int SLP_MAIN_PD_BIT = 4;
    localparam int SLP_DIG_PD_BIT = 5;
    // Status
    localparam int STS_ENGINE_OFF_BIT = 0;
    localparam int STS_FLUSH_BIT = 1;
    localparam int STS_GATE_BIT = 2;
    // Serial instruction byte: read flag
    localparam int INSTR_READ_BIT = 7;

    // ------------------------------------------------------------------
    // Synchroniser lanes
    // ------------------------------------------------------------------
    localparam int SYN_SCLK = 0;
    localparam int SYN_SEL_N = 1;
    localparam int SYN_SDIO = 2;
    localparam int SYN_GATE = 3;
    localparam int SYN_WIDTH = 4;

    // ------------------------------------------------------------------
    // Counts
    // ------------------------------------------------------------------
    localparam logic [3:0] INSTR_LAST = 4'h7;
    localparam logic [3:0] FRAME_LAST = 4'hf;
    // Core clock cycles of zero flush before the engine powers down
    localparam int FLUSH_CYCLES = 8;
    localparam logic [3:0] FLUSH_LAST = 4'(FLUSH_CYCLES - 1);

    // ------------------------------------------------------------------
    // Flush sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_FLUSH = 2'h1,
        ST_OFF = 2'h2
    } flush_state_t;

endpackage : power_pkg

// ===== pkg/gate_ctrl_if.sv
// Interface between the top level and the transmit-gate flush sequencer
`timescale 1ns/10ps
`default_nettype none
interface gate_ctrl_if;
    logic gate;
    logic auto_en;
    logic flush;
    logic engine_off;

    modport seq (
        input gate,
        input auto_en,
        output flush,
        output engine_off
    );

    modport top (
        output gate,
        output auto_en,
        input flush,
        input engine_off
    );
endinterface : gate_ctrl_if
`default_nettype wire

// ===== src/flush_seq.sv
// Transmit-gate flush and automatic digital engine power-down sequencer
`timescale 1ns/10ps
`default_nettype none
module flush_seq
    import power_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    gate_ctrl_if.seq ctl
);

    // ------------------------------------------------------------------
    // State and flush counter
    // ------------------------------------------------------------------
    flush_state_t state_reg;
    flush_state_t state_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic cnt_done;

    assign cnt_done = (cnt_reg == FLUSH_LAST);

    // Next state from gate level and auto power-down enable
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RUN: begin
                if (!ctl.gate) begin
                    state_next = ST_FLUSH;
                end
            end
            ST_FLUSH: begin
                if (ctl.gate) begin
                    state_next = ST_RUN;
                end else if (ctl.auto_en && cnt_done) begin
                    state_next = ST_OFF;
                end
            end
            ST_OFF: begin
                if (ctl.gate) begin
                    state_next = ST_RUN;
                end else if (!ctl.auto_en) begin
                    state_next = ST_FLUSH;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    // Counter runs only while flushing
    assign cnt_next = (state_reg == ST_FLUSH && !cnt_done) ? cnt_reg + 4'h1 :
                      (state_reg == ST_FLUSH) ? cnt_reg : 4'h0;

    // State registers
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state_reg <= ST_RUN;
            cnt_reg <= 4'h0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
        end
    end

    // Zeros flow whenever the gate is low; engine off only after flush
    assign ctl.flush = (state_reg != ST_RUN);
    assign ctl.engine_off = (state_reg == ST_OFF);

endmodule : flush_seq
`default_nettype wire

// ===== src/power_down_sleep_control.sv
// Power-down and sleep control with three-wire configuration port
//
// Operation
// - Full power-down switches off everything, reference too
// - Configuration port keeps working during full power-down
// - Sleep turns main output off, reference stays
// - Engine and main power-downs and auxiliary sleeps in any combination
// - Auxiliary converters sleep independently via port
// - Auto enable decides engine power-down on gate low
// - Gate low, auto off: flush zeros, stay powered
// - Gate low, auto on: flush, then engine off
`timescale 1ns/10ps
`default_nettype none
module power_down_sleep_control
    import power_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic serial_clk_i,
    input wire logic serial_sel_n_i,
    input wire logic sdio_i,
    output logic sdio_o,
    output logic sdio_oe_o,
    input wire logic transmit_gate_i,
    output logic reference_on_o,
    output logic main_bias_on_o,
    output logic [1:0] main_out_on_o,
    output logic [1:0] aux_on_o,
    output logic digital_engine_on_o,
    output logic flush_zero_o
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [SYN_WIDTH-1:0] pins;
    logic [SYN_WIDTH-1:0] sync1_reg;
    logic [SYN_WIDTH-1:0] sync2_reg;
    logic [SYN_WIDTH-1:0] sync3_reg;

    // Carrier to the flush sequencer, declared ahead of the status read
    gate_ctrl_if gate_ctl ();

    assign pins = {transmit_gate_i, sdio_i, serial_sel_n_i, serial_clk_i};

    // Two stages, third only for edge detection
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sync1_reg <= 4'ha; // Idle: gate high, deselected, clock low
            sync2_reg <= 4'ha;
            sync3_reg <= 4'ha;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // ------------------------------------------------------------------
    // Serial frame decode
    // ------------------------------------------------------------------
    logic sel;
    logic sclk_rise;
    logic sclk_fall;
    logic [7:0] shift_next;
    logic instr_done;
    logic wr_stb;
    logic rd_phase;
    logic [7:0] rd_data;
    logic [7:0] status_val;

    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic instr_rd_reg;
    logic [4:0] instr_addr_reg;
    logic [7:0] rd_shift_reg;
    logic sdio_o_reg;
    logic sdio_oe_reg;
    logic [7:0] power_mode_reg;
    logic [7:0] sleep_ctrl_reg;

    // Edges and strobes, all in the core clock domain
    assign sel = ~sync2_reg[SYN_SEL_N];
    assign sclk_rise = sync2_reg[SYN_SCLK] & ~sync3_reg[SYN_SCLK];
    assign sclk_fall = ~sync2_reg[SYN_SCLK] & sync3_reg[SYN_SCLK];
    assign shift_next = {shift_reg[6:0], sync2_reg[SYN_SDIO]};
    assign instr_done = sel & sclk_rise & (bit_cnt_reg == INSTR_LAST);
    assign wr_stb = sel & sclk_rise & (bit_cnt_reg == FRAME_LAST) & ~instr_rd_reg;
    assign rd_phase = sel & instr_rd_reg & bit_cnt_reg[3];

    // Read multiplexer, addressed by the instruction just shifted in
    assign status_val = {5'h00, sync2_reg[SYN_GATE], gate_ctl.flush, gate_ctl.engine_off};
    assign rd_data = (shift_next[4:0] == ADDR_POWER_MODE) ? power_mode_reg :
                     (shift_next[4:0] == ADDR_SLEEP_CTRL) ? sleep_ctrl_reg :
                     (shift_next[4:0] == ADDR_STATUS) ? status_val : 8'h00;

    // Bit counter and shifter
    always_ff @(posedge core_clk_i) begin
        if (rst_i || !sel) begin
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
        end else if (sclk_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            shift_reg <= shift_next;
        end
    end

    // Instruction capture
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            instr_rd_reg <= 1'b0;
            instr_addr_reg <= 5'h00;
        end else if (instr_done) begin
            instr_rd_reg <= shift_next[INSTR_READ_BIT];
            instr_addr_reg <= shift_next[4:0];
        end
    end

    // Read shifter, driven out on falling serial clock
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rd_shift_reg <= 8'h00;
            sdio_o_reg <= 1'b0;
        end else if (instr_done) begin
            rd_shift_reg <= rd_data;
        end else if (rd_phase && sclk_fall) begin
            sdio_o_reg <= rd_shift_reg[7];
            rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
        end
    end

    // Output enable only during the data half of a read
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sdio_oe_reg <= 1'b0;
        end else begin
            sdio_oe_reg <= rd_phase;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers, written regardless of power state
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            power_mode_reg <= POWER_MODE_RESET;
            sleep_ctrl_reg <= SLEEP_CTRL_RESET;
        end else if (wr_stb) begin
            if (instr_addr_reg == ADDR_POWER_MODE) begin
                power_mode_reg <= shift_next;
            end
            if (instr_addr_reg == ADDR_SLEEP_CTRL) begin
                sleep_ctrl_reg <= shift_next;
            end
        end
    end

    // ------------------------------------------------------------------
    // Transmit gate sequencer
    // ------------------------------------------------------------------
    assign gate_ctl.gate = sync2_reg[SYN_GATE];
    assign gate_ctl.auto_en = power_mode_reg[PWR_AUTO_PD_BIT];

    flush_seq u_flush_seq (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .ctl(gate_ctl)
    );

    // ------------------------------------------------------------------
    // Power enables
    // ------------------------------------------------------------------
    logic full_pd;
    logic main_pd;
    logic dig_pd;
    logic [1:0] main_sleep;
    logic [1:0] aux_sleep;
    logic [1:0] main_out_next;
    logic [1:0] aux_next;
    logic engine_next;

    assign full_pd = power_mode_reg[PWR_FULL_PD_BIT];
    assign main_pd = sleep_ctrl_reg[SLP_MAIN_PD_BIT];
    assign dig_pd = sleep_ctrl_reg[SLP_DIG_PD_BIT];
    assign main_sleep = sleep_ctrl_reg[SLP_MAIN_SLEEP_LSB +: 2];
    assign aux_sleep = sleep_ctrl_reg[SLP_AUX_SLEEP_LSB +: 2];

    // Each block gated by its own bit, all by full power-down
    assign main_out_next = (full_pd || main_pd) ? 2'h0 : ~main_sleep;
    assign aux_next = full_pd ? 2'h0 : ~aux_sleep;
    assign engine_next = ~full_pd & ~dig_pd & ~gate_ctl.engine_off;

    // Registered power outputs
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            reference_on_o <= 1'b1;
            main_bias_on_o <= 1'b1;
            main_out_on_o <= 2'h3;
            aux_on_o <= 2'h3;
            digital_engine_on_o <= 1'b1;
            flush_zero_o <= 1'b0;
        end else begin
            reference_on_o <= ~full_pd;
            main_bias_on_o <= ~full_pd & ~main_pd;
            main_out_on_o <= main_out_next;
            aux_on_o <= aux_next;
            digital_engine_on_o <= engine_next;
            flush_zero_o <= gate_ctl.flush;
        end
    end

    assign sdio_o = sdio_o_reg;
    assign sdio_oe_o = sdio_oe_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    sequence gate_low_manual;
        (!gate_ctl.gate && !gate_ctl.auto_en) [*2];
    endsequence

    // Cycles of gate low with auto power-down, saturating helper count
    logic [3:0] auto_low_cnt_reg;

    always_ff @(posedge core_clk_i) begin
        if (rst_i || gate_ctl.gate || !gate_ctl.auto_en) begin
            auto_low_cnt_reg <= 4'h0;
        end else if (auto_low_cnt_reg != 4'hf) begin
            auto_low_cnt_reg <= auto_low_cnt_reg + 4'h1;
        end
    end

    // Flush length plus state and output register stages
    sequence gate_low_auto;
        auto_low_cnt_reg >= 4'(FLUSH_CYCLES + 2);
    endsequence

    a_full_pd_all_off: assert property (
        full_pd |=> (!reference_on_o && !main_bias_on_o && main_out_on_o == 2'h0
                     && aux_on_o == 2'h0 && !digital_engine_on_o))
        else $error("Full power-down left a block powered");

    a_port_alive_pd: assert property (
        (full_pd && wr_stb && instr_addr_reg == ADDR_SLEEP_CTRL)
            |=> (sleep_ctrl_reg == $past(shift_next)))
        else $error("Register write lost during full power-down");

    a_sleep_keeps_ref: assert property (
        (!full_pd && !main_pd && main_sleep == 2'h3)
            |=> (reference_on_o && main_bias_on_o && main_out_on_o == 2'h0))
        else $error("Sleep state wrong on reference or main output");

    a_engine_pd_alone: assert property (
        (!full_pd && dig_pd && !main_pd && main_sleep == 2'h0)
            |=> (!digital_engine_on_o && main_out_on_o == 2'h3 && reference_on_o))
        else $error("Engine power-down disturbed other blocks");

    a_aux_sleep_indep: assert property (
        (!full_pd && aux_sleep == 2'h1) |=> (aux_on_o == 2'h2 && reference_on_o))
        else $error("Auxiliary sleep not independent");

    a_auto_bit_decides: assert property (
        (!gate_ctl.gate && !gate_ctl.auto_en) |=> !gate_ctl.engine_off)
        else $error("Engine off without auto power-down enable");

    a_flush_manual: assert property (
        gate_low_manual |=> (flush_zero_o
                             && digital_engine_on_o == ~($past(full_pd) | $past(dig_pd))))
        else $error("Manual flush not zero or not powered");

    a_flush_then_off: assert property (
        ($fell(gate_ctl.gate) && gate_ctl.auto_en) |-> (!gate_ctl.engine_off) [*4])
        else $error("Engine powered down before flush");

    a_auto_engine_off: assert property (
        gate_low_auto |-> (!digital_engine_on_o && reference_on_o == !$past(full_pd)))
        else $error("Engine not powered down after flush");

    a_gate_resume: assert property (
        $rose(gate_ctl.gate) |=> ##1 (!flush_zero_o
                                      && digital_engine_on_o == ~($past(full_pd) | $past(dig_pd))))
        else $error("Data path did not resume after gate high");

endmodule : power_down_sleep_control
`default_nettype wire

// ===== test/host_model.sv
// Host model driving the transmit gate and the three-wire configuration port
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input wire logic core_clk_i,
    input wire logic dev_sdio_i,
    input wire logic dev_sdio_oe_i,
    output var logic serial_clk_o,
    output var logic serial_sel_n_o,
    output logic sdio_o,
    output var logic transmit_gate_o
);
    logic drv;
    logic bit_val;
    logic toggle_reg;

    // Idle levels: clock low, port deselected, gate high
    initial begin
        serial_clk_o = 1'h0;
        serial_sel_n_o = 1'h1;
        transmit_gate_o = 1'h1;
        drv = 1'h0;
        bit_val = 1'h0;
        toggle_reg = 1'h0;
    end

    // Undriven data line shows a changing pattern, never a stale bit
    always @(posedge core_clk_i) toggle_reg <= ~toggle_reg;
    assign sdio_o = drv ? bit_val : (dev_sdio_oe_i ? dev_sdio_i : toggle_reg);

    // Half a serial clock period: six core clocks, well above the minimum
    task automatic half_wait();
        repeat (6) @(posedge core_clk_i);
        #1;
    endtask : half_wait

    // One 16-bit frame, MSB first; data driven while the serial clock is low
    task automatic xfer(input logic rd, input logic [4:0] addr, input logic [7:0] wdata,
                        output logic [7:0] rdata);
        logic [15:0] word;
        word = {rd, 2'h0, addr, wdata};
        rdata = 8'h00;
        serial_sel_n_o = 1'h0;
        for (int i = 15; i >= 0; i--) begin
            drv = (i > 7) || !rd;
            bit_val = word[i];
            half_wait();
            if (i < 8) rdata[i] = sdio_o;
            serial_clk_o = 1'h1;
            half_wait();
            serial_clk_o = 1'h0;
        end
        drv = 1'h0;
        half_wait();
        serial_sel_n_o = 1'h1;
        half_wait();
    endtask : xfer

    task automatic set_gate(input logic v);
        transmit_gate_o = v;
    endtask : set_gate
endmodule : host_model
`default_nettype wire

// ===== test/test_power_down_sleep_control.sv
// Self-checking testbench for the power-down and sleep control block
`timescale 1ns/10ps
`default_nettype none
module test_power_down_sleep_control
    import power_pkg::*;
;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic sclk;
    logic sel_n;
    logic sdio_in;
    logic sdio_out;
    logic sdio_oe;
    logic gate;
    logic ref_on;
    logic bias_on;
    logic [1:0] main_on;
    logic [1:0] aux_on;
    logic eng_on;
    logic flush;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    wire logic [7:0] pwr = {1'h0, ref_on, bias_on, main_on, aux_on, eng_on};

    power_down_sleep_control power_down_sleep_control_inst (
        .core_clk_i(core_clk), .rst_i(rst), .serial_clk_i(sclk), .serial_sel_n_i(sel_n),
        .sdio_i(sdio_in), .sdio_o(sdio_out), .sdio_oe_o(sdio_oe), .transmit_gate_i(gate),
        .reference_on_o(ref_on), .main_bias_on_o(bias_on), .main_out_on_o(main_on),
        .aux_on_o(aux_on), .digital_engine_on_o(eng_on), .flush_zero_o(flush)
    );

    host_model host_model_inst (
        .core_clk_i(core_clk), .dev_sdio_i(sdio_out), .dev_sdio_oe_i(sdio_oe),
        .serial_clk_o(sclk), .serial_sel_n_o(sel_n), .sdio_o(sdio_in),
        .transmit_gate_o(gate)
    );

    // Clock and hang limit
    initial forever #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 15000) begin
            err_count++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [4:0] addr, input logic [7:0] data);
        logic [7:0] dummy;
        host_model_inst.xfer(1'h0, addr, data, dummy);
    endtask : wr

    task automatic rd(input logic [4:0] addr, output logic [7:0] data);
        host_model_inst.xfer(1'h1, addr, 8'h00, data);
    endtask : rd

    // Expected power outputs from the two control registers
    function automatic logic [7:0] exp_pwr(input logic [7:0] pm, input logic [7:0] sc,
                                           input logic aoff);
        logic fpd;
        logic bias;
        fpd = pm[PWR_FULL_PD_BIT];
        bias = !fpd && !sc[SLP_MAIN_PD_BIT];
        return {1'h0, !fpd, bias, bias && !sc[SLP_MAIN_SLEEP_LSB + 1],
                bias && !sc[SLP_MAIN_SLEEP_LSB], !fpd && !sc[SLP_AUX_SLEEP_LSB + 1],
                !fpd && !sc[SLP_AUX_SLEEP_LSB], !fpd && !sc[SLP_DIG_PD_BIT] && !aoff};
    endfunction : exp_pwr

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_reset();
        logic [7:0] v;
        chk(pwr, exp_pwr(8'h00, 8'h00, 1'h0), "reset power");
        chk({6'h00, flush, sdio_oe}, 8'h00, "reset flush/oe");
        rd(ADDR_POWER_MODE, v);
        chk(v, POWER_MODE_RESET, "reset mode reg");
        rd(ADDR_SLEEP_CTRL, v);
        chk(v, SLEEP_CTRL_RESET, "reset sleep reg");
        $display("test reset done");
    endtask : test_reset

    task automatic test_sleep();
        logic [7:0] vals [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h08, 8'h10, 8'h20, 8'h3C, 8'h00};
        logic [7:0] v;
        foreach (vals[i]) begin
            wr(ADDR_SLEEP_CTRL, vals[i]);
            cyc(2);
            chk(pwr, exp_pwr(8'h00, vals[i], 1'h0), "sleep combo");
            rd(ADDR_SLEEP_CTRL, v);
            chk(v, vals[i], "sleep readback");
        end
        $display("test sleep done");
    endtask : test_sleep

    task automatic test_full_pd();
        logic [7:0] v;
        wr(ADDR_POWER_MODE, 8'h10);
        cyc(2);
        chk(pwr, exp_pwr(8'h10, 8'h00, 1'h0), "full power-down");
        rd(ADDR_POWER_MODE, v);
        chk(v, 8'h10, "port alive read");
        wr(ADDR_SLEEP_CTRL, 8'h0C);
        rd(ADDR_SLEEP_CTRL, v);
        chk(v, 8'h0C, "port alive write");
        wr(ADDR_POWER_MODE, 8'h00);
        cyc(2);
        chk(pwr, exp_pwr(8'h00, 8'h0C, 1'h0), "leave power-down");
        wr(ADDR_SLEEP_CTRL, 8'h00);
        wr(ADDR_STATUS, 8'hFF);
        rd(ADDR_STATUS, v);
        chk(v, 8'(1 << STS_GATE_BIT), "status read-only");
        rd(5'h1F, v);
        chk(v, 8'h00, "unmapped read");
        $display("test full power-down done");
    endtask : test_full_pd

    task automatic test_gate_plain();
        logic [7:0] v;
        host_model_inst.set_gate(1'h0);
        cyc(20);
        chk({7'h00, flush}, 8'h01, "flush without auto");
        chk(pwr, exp_pwr(8'h00, 8'h00, 1'h0), "stay powered");
        rd(ADDR_STATUS, v);
        chk(v, 8'(1 << STS_FLUSH_BIT), "status flushing");
        host_model_inst.set_gate(1'h1);
        cyc(8);
        chk({7'h00, flush}, 8'h00, "flush released");
        $display("test gate plain done");
    endtask : test_gate_plain

    task automatic test_gate_auto();
        logic [7:0] v;
        wr(ADDR_POWER_MODE, 8'h08);
        host_model_inst.set_gate(1'h0);
        cyc(7);
        chk({6'h00, flush, eng_on}, 8'h03, "flush before engine off");
        cyc(13);
        chk(pwr, exp_pwr(8'h08, 8'h00, 1'h1), "engine off only");
        rd(ADDR_STATUS, v);
        chk(v, 8'((1 << STS_ENGINE_OFF_BIT) | (1 << STS_FLUSH_BIT)), "status off");
        host_model_inst.set_gate(1'h1);
        cyc(8);
        chk(pwr, exp_pwr(8'h08, 8'h00, 1'h0), "engine back on");
        chk({7'h00, flush}, 8'h00, "flush ends");
        host_model_inst.set_gate(1'h0);
        cyc(20);
        wr(ADDR_POWER_MODE, 8'h00);
        chk({6'h00, flush, eng_on}, 8'h03, "auto cleared while off");
        host_model_inst.set_gate(1'h1);
        cyc(8);
        chk({7'h00, flush}, 8'h00, "flush ends again");
        $display("test gate auto done");
    endtask : test_gate_auto

    // ------------------------------------------------------------------
    // Main sequence and verdict
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        cyc(20);
        rst = 1'h0;
        cyc(5);
        test_reset();
        test_sleep();
        test_full_pd();
        test_gate_plain();
        test_gate_auto();
        report_and_stop();
    end
endmodule : test_power_down_sleep_control
`default_nettype wire
